// File: core/ftt_pkg.sv
// package: register map, field positions, reset values and fifo levels
package ftt_pkg;
  localparam logic [7:0] TEST_MODE_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] FIFO_FILL_STATUS_ADDR  = 8'h1C;
  localparam logic [7:0] TX_LENGTH_HIGH_ADDR    = 8'h1D;
  localparam logic [7:0] TX_LENGTH_LOW_ADDR     = 8'h1E;
  localparam logic [7:0] IRQ_STATUS_ADDR        = 8'h1F;
  localparam logic [7:0] IRQ_MASK_ADDR          = 8'h20;
  localparam logic [7:0] TEST_RESET  = 8'h00;
  localparam logic [7:0] LEN_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  // test mode control fields
  localparam int FAST_CODER_CLOCK_BIT = 0;
  localparam int DECODER_CHECK_BIT    = 1;
  localparam int IO_CHECK_LO_BIT      = 2;
  localparam int IO_CHECK_HI_BIT      = 3;
  localparam int CARRIER_AMP_BIT      = 7;
  // fifo status fields
  localparam int OVERFLOW_BIT       = 4;
  localparam int LOW_WATERMARK_BIT  = 5;
  localparam int HIGH_WATERMARK_BIT = 6;
  // interrupt status fields
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_HIGH_BIT     = 1;
  localparam int IRQ_LOW_BIT      = 2;
  localparam int IRQ_STOP_BIT     = 3;
  // fifo levels
  localparam int               FIFO_DEPTH  = 12;
  localparam logic [4:0] HIGH_LEVEL  = 5'h09;
  localparam logic [4:0] LOW_LEVEL   = 5'h03;
  localparam logic [4:0] FULL_LEVEL  = 5'h0C;
endpackage : ftt_pkg

// File: core/ftt_regs.sv
// fifo status, transmit length and test mode control registers
`timescale 1ns/1ps
`default_nettype none
module ftt_regs (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       chipEnable,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic [4:0] fifoCount,
  input  wire logic       fifoHostWrite,
  input  wire logic       rxActive,
  input  wire logic       txActive,
  input  wire logic       stopCondition,
  input  wire logic       txFrameEnd,
  input  wire logic       carrierClkEn,
  input  wire logic       dividedCoderClkEn,
  output logic            coderClkEn,
  output logic            testModeActive,
  output logic            decoderCheck,
  output logic      [1:0] ioCheckSelect,
  output logic            carrierAmplitudeCheck,
  output logic     [11:0] txByteCount,
  output logic      [2:0] partialByteBits,
  output logic            partialByteFlag,
  output logic      [2:0] txLastByteBits,
  output logic            irq
);
  logic [7:0] testCtl_q;
  logic [7:0] lenHigh_q;
  logic [7:0] lenLow_q;
  logic       overflow_q;
  logic       testMode_q;
  logic [3:0] irqStatus_q;
  logic [3:0] irqMask_q;
  logic [7:0] rdData_q;
  logic [7:0] fifoStatus;
  logic       highMark;
  logic       lowMark;
  logic       overflowEvt;
  logic       wrTest;
  logic       highMarkPrev_q;
  logic       lowMarkPrev_q;
  logic [3:0] irqEvents;

  //////////////////////////////////////////////////////////////////////////
  // decode and status flags
  assign wrTest = regWr && regAddr == ftt_pkg::TEST_MODE_CONTROL_ADDR;
  assign highMark = rxActive && fifoCount >= ftt_pkg::HIGH_LEVEL;
  assign lowMark  = txActive && fifoCount <= ftt_pkg::LOW_LEVEL;
  assign overflowEvt = fifoHostWrite &&
                       fifoCount >= ftt_pkg::FULL_LEVEL;

  // status byte: reserved top bit, flags, count minus one
  always_comb begin
    fifoStatus = 8'h00;
    fifoStatus[ftt_pkg::HIGH_WATERMARK_BIT] = highMark;
    fifoStatus[ftt_pkg::LOW_WATERMARK_BIT]  = lowMark;
    fifoStatus[ftt_pkg::OVERFLOW_BIT]       = overflow_q;
    fifoStatus[3:0] = fifoCount[3:0] - 4'h1;
    if (fifoCount == 5'h00) begin
      fifoStatus[3:0] = 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // test mode control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      testCtl_q <= ftt_pkg::TEST_RESET;
    end else if (!chipEnable) begin
      testCtl_q <= ftt_pkg::TEST_RESET;
    end else if (wrTest) begin
      testCtl_q <= regWrData;
    end else if (stopCondition) begin
      testCtl_q[ftt_pkg::DECODER_CHECK_BIT] <= 1'b0;
      testCtl_q[ftt_pkg::IO_CHECK_LO_BIT]   <= 1'b0;
      testCtl_q[ftt_pkg::IO_CHECK_HI_BIT]   <= 1'b0;
    end
  end

  // test mode entry and persistence until stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      testMode_q <= 1'b0;
    end else if (!chipEnable) begin
      testMode_q <= 1'b0;
    end else if (wrTest && (regWrData[ftt_pkg::DECODER_CHECK_BIT] ||
                 regWrData[ftt_pkg::IO_CHECK_LO_BIT] ||
                 regWrData[ftt_pkg::IO_CHECK_HI_BIT])) begin
      testMode_q <= 1'b1;
    end else if (stopCondition) begin
      testMode_q <= 1'b0;
    end
  end

  assign testModeActive        = testMode_q;
  assign decoderCheck          = testCtl_q[ftt_pkg::DECODER_CHECK_BIT];
  assign ioCheckSelect         = testCtl_q[ftt_pkg::IO_CHECK_HI_BIT:
                                           ftt_pkg::IO_CHECK_LO_BIT];
  assign carrierAmplitudeCheck = testCtl_q[ftt_pkg::CARRIER_AMP_BIT];
  // coder clock pick: full carrier rate or normal divided rate
  assign coderClkEn = testCtl_q[ftt_pkg::FAST_CODER_CLOCK_BIT] ?
                      carrierClkEn : dividedCoderClkEn;

  //////////////////////////////////////////////////////////////////////////
  // transmit length registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lenHigh_q <= ftt_pkg::LEN_RESET;
    end else if (!chipEnable || txFrameEnd) begin
      lenHigh_q <= ftt_pkg::LEN_RESET;
    end else if (regWr && regAddr == ftt_pkg::TX_LENGTH_HIGH_ADDR) begin
      lenHigh_q <= regWrData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lenLow_q <= ftt_pkg::LEN_RESET;
    end else if (!chipEnable || txFrameEnd) begin
      lenLow_q <= ftt_pkg::LEN_RESET;
    end else if (regWr && regAddr == ftt_pkg::TX_LENGTH_LOW_ADDR) begin
      lenLow_q <= regWrData;
    end
  end

  assign txByteCount     = {lenHigh_q, lenLow_q[7:4]};
  assign partialByteBits = lenLow_q[3:1];
  assign partialByteFlag = lenLow_q[0];
  // bits sent from the last byte; zero means none beyond complete bytes
  assign txLastByteBits  = lenLow_q[0] ? lenLow_q[3:1] : 3'h0;

  //////////////////////////////////////////////////////////////////////////
  // overflow flag, cleared by reading the status register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overflow_q <= 1'b0;
    end else if (!chipEnable) begin
      overflow_q <= 1'b0;
    end else if (overflowEvt) begin
      overflow_q <= 1'b1;
    end else if (regRd && regAddr == ftt_pkg::FIFO_FILL_STATUS_ADDR) begin
      overflow_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt events: rising watermarks, overflow, stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      highMarkPrev_q <= 1'b0;
      lowMarkPrev_q  <= 1'b0;
    end else begin
      highMarkPrev_q <= highMark;
      lowMarkPrev_q  <= lowMark;
    end
  end

  always_comb begin
    irqEvents = 4'h0;
    irqEvents[ftt_pkg::IRQ_OVERFLOW_BIT] = overflowEvt;
    irqEvents[ftt_pkg::IRQ_HIGH_BIT]     = highMark && !highMarkPrev_q;
    irqEvents[ftt_pkg::IRQ_LOW_BIT]      = lowMark && !lowMarkPrev_q;
    irqEvents[ftt_pkg::IRQ_STOP_BIT]     = stopCondition && testMode_q;
  end

  // sticky status, read clears, new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStatus_q <= 4'h0;
    end else if (regRd && regAddr == ftt_pkg::IRQ_STATUS_ADDR) begin
      irqStatus_q <= irqEvents;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvents;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqMask_q <= ftt_pkg::MASK_RESET[3:0];
    end else if (regWr && regAddr == ftt_pkg::IRQ_MASK_ADDR) begin
      irqMask_q <= regWrData[3:0];
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        ftt_pkg::TEST_MODE_CONTROL_ADDR: rdData_q <= testCtl_q;
        ftt_pkg::FIFO_FILL_STATUS_ADDR:  rdData_q <= fifoStatus;
        ftt_pkg::TX_LENGTH_HIGH_ADDR:    rdData_q <= lenHigh_q;
        ftt_pkg::TX_LENGTH_LOW_ADDR:     rdData_q <= lenLow_q;
        ftt_pkg::IRQ_STATUS_ADDR:        rdData_q <= {4'h0, irqStatus_q};
        ftt_pkg::IRQ_MASK_ADDR:          rdData_q <= {4'h0, irqMask_q};
        default:                         rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData = rdData_q;
endmodule // ftt_regs
`default_nettype wire

// File: tb/ftt_clk_model.sv
// clock enable source standing in for the clock generator
`timescale 1ns/1ps
`default_nettype none
module ftt_clk_model (
  input  wire logic mclk,
  input  wire logic rst,
  output logic      carrierClkEn,
  output logic      dividedCoderClkEn
);
  logic [1:0] phase_q;
  // phase counter for both enables
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // carrier every other cycle, divided every fourth
  assign carrierClkEn = phase_q[0];
  assign dividedCoderClkEn = (phase_q == 2'h3);
endmodule // ftt_clk_model
`default_nettype wire

// File: tb/ftt_regs_asserts.sv
// checker for the fifo status, length and test registers
`timescale 1ns/1ps
`default_nettype none
module ftt_regs_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        chipEnable,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  input wire logic [4:0]  fifoCount,
  input wire logic        rxActive,
  input wire logic        stopCondition,
  input wire logic        txFrameEnd,
  input wire logic        testModeActive,
  input wire logic        decoderCheck,
  input wire logic [1:0]  ioCheckSelect,
  input wire logic [11:0] txByteCount,
  input wire logic [2:0]  partialByteBits,
  input wire logic        partialByteFlag,
  input wire logic [2:0]  txLastByteBits
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // status read and test write steps
  sequence s_stat; regRd && regAddr == 8'h1C; endsequence
  sequence s_test; regWr && regAddr == 8'h1B && chipEnable; endsequence
  property p_rfu; s_stat |=> regRdData[7] == 1'b0; endproperty
  a_rfu: assert property (p_rfu) else $error("top bit set");
  property p_high; s_stat |=> regRdData[6] ==
    ($past(rxActive) && $past(fifoCount) >= 5'h09); endproperty
  a_high: assert property (p_high) else $error("high flag");
  property p_cnt; s_stat |=> regRdData[3:0] == (($past(fifoCount) == 5'h00)
    ? 4'h0 : 4'($past(fifoCount) - 5'h01)); endproperty
  a_cnt: assert property (p_cnt) else $error("fill count");
  property p_test; s_test ##0 (regWrData[3:1] != 3'h0) |=> testModeActive;
  endproperty
  a_test: assert property (p_test) else $error("no test mode");
  property p_stop; stopCondition && !(regWr && regAddr == 8'h1B) |=>
    !testModeActive && !decoderCheck && ioCheckSelect == 2'h0; endproperty
  a_stop: assert property (p_stop) else $error("stop kept");
  property p_dis; !chipEnable |=> !testModeActive && txByteCount == 12'h000
    && !partialByteFlag; endproperty
  a_dis: assert property (p_dis) else $error("disable");
  property p_eof; txFrameEnd |=> txByteCount == 12'h000
    && partialByteBits == 3'h0; endproperty
  a_eof: assert property (p_eof) else $error("frame end kept");
  property p_last; txLastByteBits ==
    (partialByteFlag ? partialByteBits : 3'h0); endproperty
  a_last: assert property (p_last) else $error("last bits");
  property p_hi; regWr && regAddr == 8'h1D && chipEnable && !txFrameEnd
    |=> txByteCount[11:4] == $past(regWrData); endproperty
  a_hi: assert property (p_hi) else $error("count high");
endmodule // ftt_regs_asserts
bind ftt_regs ftt_regs_asserts u_asserts (
  .mclk            (mclk),
  .rst             (rst),
  .chipEnable      (chipEnable),
  .regAddr         (regAddr),
  .regWrData       (regWrData),
  .regWr           (regWr),
  .regRd           (regRd),
  .regRdData       (regRdData),
  .fifoCount       (fifoCount),
  .rxActive        (rxActive),
  .stopCondition   (stopCondition),
  .txFrameEnd      (txFrameEnd),
  .testModeActive  (testModeActive),
  .decoderCheck    (decoderCheck),
  .ioCheckSelect   (ioCheckSelect),
  .txByteCount     (txByteCount),
  .partialByteBits (partialByteBits),
  .partialByteFlag (partialByteFlag),
  .txLastByteBits  (txLastByteBits)
);
`default_nettype wire

// File: tb/tb_fifo_txlen_test_regs.sv
// self-checking bench for the fifo status, length and test registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_fifo_txlen_test_regs;
  logic mclk = 0, rst = 1, chipEnable = 1, regWr = 0, regRd = 0, irq;
  logic rxActive = 0, txActive = 0, stopCondition = 0, txFrameEnd = 0;
  logic fifoHostWrite = 0, carrierClkEn, dividedCoderClkEn, coderClkEn;
  logic testModeActive, decoderCheck, carrierAmplitudeCheck, partialByteFlag;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData, rdv;
  logic [4:0] fifoCount = 0;
  logic [1:0] ioCheckSelect;
  logic [11:0] txByteCount;
  logic [2:0] partialByteBits, txLastByteBits;
  int errors = 0, comparisons = 0;
  always #2 mclk = ~mclk;
  ftt_clk_model u_clk (.mclk, .rst, .carrierClkEn, .dividedCoderClkEn);
  ftt_regs DUT (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 `CHK("regRdData", e, regRdData)
  endtask
  // k: 0 stop, 1 fifo write, 2 frame end
  task automatic pulse(input int k);
    @(posedge mclk);
    {txFrameEnd, fifoHostWrite, stopCondition} <= 3'b001 << k;
    @(posedge mclk);
    {txFrameEnd, fifoHostWrite, stopCondition} <= 3'b000;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic ck_coder(input logic fast);
    repeat (4) begin
      @(posedge mclk);
      #1;
      `CHK("coderClkEn", fast ? carrierClkEn : dividedCoderClkEn,
        coderClkEn)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_test;
    logic [7:0] m [3] = '{8'h02, 8'h04, 8'h88};
    foreach (m[i]) begin
      wr(8'h1B, m[i] | 8'h01);
      `CHK("testModeActive", 1'b1, testModeActive)
      `CHK("decoderCheck", m[i][1], decoderCheck)
      `CHK("ioCheckSelect", m[i][3:2], ioCheckSelect)
      ck_coder(1'b1);
      pulse(0);
      `CHK("testModeActive", 1'b0, testModeActive)
      `CHK("ioCheckSelect", 2'h0, ioCheckSelect)
      `CHK("carrierAmplitudeCheck", m[i][7], carrierAmplitudeCheck)
      rc(8'h1B, (m[i] & 8'h80) | 8'h01);
    end
    wr(8'h1B, 8'h00);
    ck_coder(1'b0);
  endtask
  task automatic t_stat;
    logic [6:0] v [6] = '{7'h49, 7'h48, 7'h23, 7'h24, 7'h20, 7'h4C};
    logic [7:0] ex;
    foreach (v[i]) begin
      @(posedge mclk);
      {rxActive, txActive, fifoCount} <= v[i];
      ex = {1'b0, v[i][6] && v[i][4:0] >= 5'h09,
            v[i][5] && v[i][4:0] <= 5'h03, 1'b0,
            v[i][4:0] == 5'h00 ? 4'h0 : 4'(v[i][4:0] - 5'h01)};
      rc(8'h1C, ex);
    end
  endtask
  task automatic t_ovf;
    rc(8'h1F, 8'h0E);
    wr(8'h20, 8'h01);
    pulse(1);
    `CHK("irq", 1'b1, irq)
    rc(8'h1C, 8'h5B);
    rc(8'h1C, 8'h4B);
    rc(8'h1F, 8'h01);
    `CHK("irq", 1'b0, irq)
    wr(8'h20, 8'h00);
    pulse(1);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_len;
    rc(8'h1D, 8'h00);
    rc(8'h05, 8'h00);
    wr(8'h1D, 8'hA5);
    wr(8'h1E, 8'h3B);
    `CHK("txByteCount", 12'hA53, txByteCount)
    `CHK("txLastByteBits", 3'h5, txLastByteBits)
    `CHK("partialByteBits", 3'h5, partialByteBits)
    `CHK("partialByteFlag", 1'b1, partialByteFlag)
    wr(8'h1E, 8'h3A);
    `CHK("txLastByteBits", 3'h0, txLastByteBits)
    `CHK("partialByteFlag", 1'b0, partialByteFlag)
    pulse(2);
    rc(8'h1E, 8'h00);
    wr(8'h1D, 8'hFF);
    wr(8'h1B, 8'h84);
    @(posedge mclk);
    chipEnable <= 1'b0;
    @(posedge mclk);
    chipEnable <= 1'b1;
    rc(8'h1D, 8'h00);
    rc(8'h1B, 8'h00);
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rc(8'h1B, 8'h00);
    t_test;
    t_stat;
    t_ovf;
    t_len;
    close_out;
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    close_out;
  end
endmodule // tb_fifo_txlen_test_regs
`default_nettype wire
